// ### cbad_pkg.sv
// Package: address map, targets and bus carriers for the bus decoder
package cbad_pkg;

    localparam logic [31:0] IBUS_LO      = 32'h4000_0000;
    localparam logic [31:0] SHARED_LO    = 32'h5000_0000;
    localparam logic [31:0] DEXT_LO      = 32'h3C00_0000;
    localparam logic [31:0] DEXT_HI      = 32'h3C7F_FFFF;
    localparam logic [31:0] DSRAM1_LO    = 32'h3FC8_0000;
    localparam logic [31:0] DSRAM1_HI    = 32'h3FCD_FFFF;
    localparam logic [31:0] DROM1_LO     = 32'h3FF0_0000;
    localparam logic [31:0] DROM1_HI     = 32'h3FF1_FFFF;
    localparam logic [31:0] IROM0_LO     = 32'h4000_0000;
    localparam logic [31:0] IROM0_HI     = 32'h4003_FFFF;
    localparam logic [31:0] IROM1_LO     = 32'h4004_0000;
    localparam logic [31:0] IROM1_HI     = 32'h4005_FFFF;
    localparam logic [31:0] ISRAM0_LO    = 32'h4037_C000;
    localparam logic [31:0] ISRAM0_HI    = 32'h4037_FFFF;
    localparam logic [31:0] ISRAM1_LO    = 32'h4038_0000;
    localparam logic [31:0] ISRAM1_HI    = 32'h403D_FFFF;
    localparam logic [31:0] IEXT_LO      = 32'h4200_0000;
    localparam logic [31:0] IEXT_HI      = 32'h427F_FFFF;
    localparam logic [31:0] RTC_LO       = 32'h5000_0000;
    localparam logic [31:0] RTC_HI       = 32'h5000_1FFF;
    localparam logic [31:0] PERI_LO      = 32'h6000_0000;
    localparam logic [31:0] PERI_HI      = 32'h600D_0FFF;

    // Access sizes: byte, half word, word
    localparam logic [1:0]  SIZE_B       = 2'h0;
    localparam logic [1:0]  SIZE_H       = 2'h1;
    localparam logic [1:0]  SIZE_W       = 2'h2;

    // Requester identity: processor or another bus master
    localparam logic        MST_CPU      = 1'h0;

    // Decoded targets, one-hot
    typedef enum logic [7:0] {
        CBAD_T_NONE  = 8'h00,
        CBAD_T_ROM0  = 8'h01,
        CBAD_T_ROM1  = 8'h02,
        CBAD_T_SRAM0 = 8'h04,
        CBAD_T_SRAM1 = 8'h08,
        CBAD_T_RTC   = 8'h10,
        CBAD_T_EXT   = 8'h20,
        CBAD_T_PERI  = 8'h40
    } cbad_target_t;

    // Request from one bus master port
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        master;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } cbad_req_t;

    // Response back to a master
    typedef struct packed {
        logic        done;
        logic        err;
        logic [31:0] rdata;
    } cbad_rsp_t;

    // Routed request to a downstream target
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  target;
        logic [31:0] offset;
        logic [3:0]  strb;
        logic [31:0] wdata;
    } cbad_route_t;

endpackage

// ### cbad_decode.sv
// Address classifier: maps one address on one bus to a target and offset
`timescale 1ns/1ns
`default_nettype none
module cbad_decode
    import cbad_pkg::*;
(
    input  wire logic        is_ibus,
    input  wire logic [31:0] addr,
    output var  logic [7:0]  target,
    output var  logic [31:0] offset
);

    function automatic logic in_rng(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    always_comb begin
        target = CBAD_T_NONE;
        offset = 32'h0000_0000;
        if (addr < IBUS_LO) begin
            // Data-only region
            if (!is_ibus) begin
                if (in_rng(addr, DEXT_LO, DEXT_HI)) begin
                    target = CBAD_T_EXT;
                    offset = addr - DEXT_LO;
                end else if (in_rng(addr, DSRAM1_LO, DSRAM1_HI)) begin
                    target = CBAD_T_SRAM1;
                    offset = addr - DSRAM1_LO;
                end else if (in_rng(addr, DROM1_LO, DROM1_HI)) begin
                    target = CBAD_T_ROM1;
                    offset = addr - DROM1_LO;
                end
            end
        end else if (addr < SHARED_LO) begin
            // Instruction-only region
            if (is_ibus) begin
                if (in_rng(addr, IROM0_LO, IROM0_HI)) begin
                    target = CBAD_T_ROM0;
                    offset = addr - IROM0_LO;
                end else if (in_rng(addr, IROM1_LO, IROM1_HI)) begin
                    target = CBAD_T_ROM1;
                    offset = addr - IROM1_LO;
                end else if (in_rng(addr, ISRAM0_LO, ISRAM0_HI)) begin
                    target = CBAD_T_SRAM0;
                    offset = addr - ISRAM0_LO;
                end else if (in_rng(addr, ISRAM1_LO, ISRAM1_HI)) begin
                    target = CBAD_T_SRAM1;
                    offset = addr - ISRAM1_LO;
                end else if (in_rng(addr, IEXT_LO, IEXT_HI)) begin
                    target = CBAD_T_EXT;
                    offset = addr - IEXT_LO;
                end
            end
        end else begin
            // Shared by both buses
            if (in_rng(addr, RTC_LO, RTC_HI)) begin
                target = CBAD_T_RTC;
                offset = addr - RTC_LO;
            end else if (in_rng(addr, PERI_LO, PERI_HI)) begin
                target = CBAD_T_PERI;
                offset = addr - PERI_LO;
            end
            // Everything else stays unmapped
        end
    end

endmodule
`default_nettype wire

// ### cbad_router.sv
// Top: dual-bus decoder and router with permission gating
// Operation
// - Addresses below 0x4000_0000 belong only to data bus space.
// - 0x4000_0000 to 0x4FFF_FFFF belong only to instruction bus space.
// - Addresses from 0x5000_0000 upward are shared by both buses.
// - Both buses place bytes on lanes little-endian.
// - Data bus allows byte, even-address half word and aligned word accesses.
// - Data 0x3C00_0000 to 0x3C7F_FFFF route to external memory cache.
// - Data 0x3FC8_0000 to 0x3FCD_FFFF select SRAM segment one.
// - Data 0x3FF0_0000 to 0x3FF1_FFFF select ROM segment one.
// - Instruction 0x4000_0000 to 0x4003_FFFF select ROM segment zero.
// - Instruction 0x4004_0000 to 0x4005_FFFF select ROM segment one.
// - Instruction 0x4037_C000 to 0x4037_FFFF select SRAM segment zero.
// - Instruction 0x4038_0000 to 0x403D_FFFF select SRAM segment one.
// - Instruction 0x4200_0000 to 0x427F_FFFF route to external cache.
// - 0x5000_0000 to 0x5000_1FFF select retention SRAM from either bus.
// - 0x6000_0000 to 0x600D_0FFF route to peripherals from either bus.
// - Unmapped gaps, including above 0x600D_0FFF, decode to no target.
// - Writes never alter either ROM segment.
// - Aliased views reach the same physical storage.
// - Internal memory is reached only with permission granted.
// - Part of internal SRAM can be assigned as cache storage.
// - Retention SRAM accepts the processor only.
// - Aliased windows map word for word at equal offsets.
// - SRAM zero used as cache blocks its instruction window.
`timescale 1ns/1ns
`default_nettype none
module cbad_router
    import cbad_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire cbad_req_t   dbus_req,
    input  wire cbad_req_t   ibus_req,
    input  wire logic [7:0]  perm_dbus,
    input  wire logic [7:0]  perm_ibus,
    input  wire logic        sram0_cache_en,
    input  wire logic [31:0] tgt_rdata,
    output var  cbad_rsp_t   dbus_rsp,
    output var  cbad_rsp_t   ibus_rsp,
    output var  cbad_route_t route,
    output var  logic        route_ibus
);

    // One access every two cycles; data bus wins a same-cycle collision and the
    // instruction bus holds its request until done.
    typedef enum logic [1:0] {
        CBAD_S_IDLE = 2'h1,
        CBAD_S_RESP = 2'h2
    } cbad_state_t;

    cbad_state_t state_reg;
    cbad_state_t state_next;

    logic        sel_ibus;
    cbad_req_t   req;
    logic [7:0]  tgt;
    logic [31:0] off;
    logic        size_ok;
    logic        perm_ok;
    logic        ok;
    logic [3:0]  strb;
    logic [31:0] wlane;
    logic        err_reg;
    logic        ibus_sel_reg;
    logic [1:0]  lane_reg;
    logic [1:0]  size_reg;

    assign sel_ibus = !dbus_req.valid && ibus_req.valid;
    assign req      = sel_ibus ? ibus_req : dbus_req;

    cbad_decode u_dec (
        .is_ibus (sel_ibus),
        .addr    (req.addr),
        .target  (tgt),
        .offset  (off)
    );

    // Lane strobes for a size and low address bits; little-endian
    function automatic logic [3:0] lane_strb(input logic [1:0] sz,
                                             input logic [1:0] a);
        case (sz)
            SIZE_B:  lane_strb = 4'h1 << a;
            SIZE_H:  lane_strb = 4'h3 << a;
            default: lane_strb = 4'hF;
        endcase
    endfunction

    always_comb begin
        if (sel_ibus) begin
            size_ok = (req.size == SIZE_W) && (req.addr[1:0] == 2'h0);
        end else begin
            case (req.size)
                SIZE_B:  size_ok = 1'b1;
                SIZE_H:  size_ok = (req.addr[0] == 1'b0);
                SIZE_W:  size_ok = (req.addr[1:0] == 2'h0);
                default: size_ok = 1'b0;
            endcase
        end
    end

    always_comb begin
        perm_ok = ((sel_ibus ? perm_ibus : perm_dbus) & tgt) != 8'h00;
        if ((tgt == CBAD_T_ROM0 || tgt == CBAD_T_ROM1) && req.write) begin
            perm_ok = 1'b0;
        end
        if (tgt == CBAD_T_RTC && req.master != MST_CPU) begin
            perm_ok = 1'b0;
        end
        if (tgt == CBAD_T_SRAM0 && sram0_cache_en) begin
            perm_ok = 1'b0;
        end
    end

    assign ok    = (tgt != CBAD_T_NONE) && size_ok && perm_ok;
    assign strb  = lane_strb(req.size, req.addr[1:0]);
    assign wlane = req.wdata << {req.addr[1:0], 3'h0};

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CBAD_S_IDLE: begin
                if (req.valid) begin
                    state_next = CBAD_S_RESP;
                end
            end
            CBAD_S_RESP: begin
                state_next = CBAD_S_IDLE;
            end
            default: begin
                state_next = CBAD_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_reg <= CBAD_S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Aliased windows share one target code and a window-relative offset,
    // so both views land on the same storage word.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            route      <= '0;
            route_ibus <= 1'b0;
        end else if (state_reg == CBAD_S_IDLE && req.valid && ok) begin
            route.valid  <= 1'b1;
            route.write  <= req.write;
            route.target <= tgt;
            route.offset <= off;
            route.strb   <= strb;
            route.wdata  <= wlane;
            route_ibus   <= sel_ibus;
        end else begin
            route.valid  <= 1'b0;
            route_ibus   <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            err_reg      <= 1'b0;
            ibus_sel_reg <= 1'b0;
            lane_reg     <= 2'h0;
            size_reg     <= 2'h0;
        end else if (state_reg == CBAD_S_IDLE && req.valid) begin
            err_reg      <= !ok;
            ibus_sel_reg <= sel_ibus;
            lane_reg     <= req.addr[1:0];
            size_reg     <= req.size;
        end
    end

    // Response one cycle after the route; target read data is aligned
    // down to lane zero and masked to the access size.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            dbus_rsp <= '0;
            ibus_rsp <= '0;
        end else if (state_reg == CBAD_S_RESP) begin
            dbus_rsp.done  <= !ibus_sel_reg;
            ibus_rsp.done  <= ibus_sel_reg;
            dbus_rsp.err   <= !ibus_sel_reg && err_reg;
            ibus_rsp.err   <= ibus_sel_reg && err_reg;
            dbus_rsp.rdata <= err_reg ? 32'h0000_0000 :
                (tgt_rdata >> {lane_reg, 3'h0}) &
                ((size_reg == SIZE_B) ? 32'h0000_00FF :
                 (size_reg == SIZE_H) ? 32'h0000_FFFF : 32'hFFFF_FFFF);
            ibus_rsp.rdata <= err_reg ? 32'h0000_0000 : tgt_rdata;
        end else begin
            dbus_rsp.done <= 1'b0;
            ibus_rsp.done <= 1'b0;
            dbus_rsp.err  <= 1'b0;
            ibus_rsp.err  <= 1'b0;
        end
    end

    rom_nowrite_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        route.valid |-> !(route.write &&
        (route.target == CBAD_T_ROM0 || route.target == CBAD_T_ROM1)))
        else $error("write routed to ROM");

    resp_timing_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (state_reg == CBAD_S_IDLE && req.valid) |-> ##2
        (dbus_rsp.done || ibus_rsp.done))
        else $error("response not two cycles after request");

    gap_error_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (state_reg == CBAD_S_IDLE && req.valid && tgt == CBAD_T_NONE) |->
        ##1 !route.valid ##1 (dbus_rsp.err || ibus_rsp.err))
        else $error("unmapped access not errored");

    perm_gate_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (state_reg == CBAD_S_IDLE && req.valid && !perm_ok) |=> !route.valid)
        else $error("refused access reached memory");

    rtc_cpu_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (state_reg == CBAD_S_IDLE && req.valid && tgt == CBAD_T_RTC &&
         req.master != MST_CPU) |-> ##2 (dbus_rsp.err || ibus_rsp.err))
        else $error("retention SRAM reached by non-processor");

    ibus_size_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (state_reg == CBAD_S_IDLE && sel_ibus && req.addr[1:0] != 2'h0)
        |=> !route.valid ##1 ibus_rsp.err)
        else $error("unaligned instruction access accepted");

    cache_blk_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        route.valid && route.target == CBAD_T_SRAM0 |->
        !$past(sram0_cache_en))
        else $error("SRAM zero reached while used as cache");

    dbus_map_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (state_reg == CBAD_S_IDLE && !sel_ibus && req.valid &&
         req.addr >= DSRAM1_LO && req.addr <= DSRAM1_HI) |->
        tgt == CBAD_T_SRAM1 && off == req.addr - DSRAM1_LO)
        else $error("data SRAM window misdecoded");

    done_pulse_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (dbus_rsp.done || ibus_rsp.done) |=>
        !(dbus_rsp.done || ibus_rsp.done))
        else $error("response done held past one cycle");

    one_resp_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !(dbus_rsp.done && ibus_rsp.done))
        else $error("both buses answered in one cycle");

    err_done_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (dbus_rsp.err |-> dbus_rsp.done) and
        (ibus_rsp.err |-> ibus_rsp.done))
        else $error("error flag without done");

    err_zero_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        dbus_rsp.err |-> dbus_rsp.rdata == 32'h0000_0000)
        else $error("errored read returned data");

    route_pulse_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        route.valid |=> !route.valid)
        else $error("route held past one cycle");

    tgt_onehot_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        route.valid |-> $onehot(route.target))
        else $error("route target not one-hot");

    route_done_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        route.valid |=> (dbus_rsp.done || ibus_rsp.done) &&
        !dbus_rsp.err && !ibus_rsp.err)
        else $error("routed access not completed cleanly");

    ibus_strb_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        route.valid && route_ibus |-> route.strb == 4'hF)
        else $error("instruction route not a full word");

    byte_mask_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (state_reg == CBAD_S_RESP && !ibus_sel_reg && size_reg == SIZE_B)
        |=> dbus_rsp.rdata[31:8] == 24'h00_0000)
        else $error("byte read not masked to lane zero");

    rtc_route_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        route.valid && route.target == CBAD_T_RTC |->
        $past(req.master) == MST_CPU)
        else $error("retention SRAM routed to non-processor");

    perm_route_a: assert property (
        @(posedge core_clk) disable iff (!rstn)
        route.valid |-> ((route_ibus ? $past(perm_ibus) : $past(perm_dbus)) &
        route.target) != 8'h00)
        else $error("route issued without permission");

    rst_quiet_a: assert property (
        @(posedge core_clk)
        !rstn |=> !route.valid && !dbus_rsp.done && !ibus_rsp.done)
        else $error("outputs active after reset");

endmodule
`default_nettype wire

// ### cbad_mem_model.sv
// Behavioural target memories seen behind the router, one store per target
`timescale 1ns/1ns
`default_nettype none
module cbad_mem_model
    import cbad_pkg::*;
(
    input  wire logic        core_clk,
    input  wire cbad_route_t route,
    output var  logic [31:0] tgt_rdata
);
    logic [31:0] mem [logic [37:0]];
    logic [37:0] key;
    logic [31:0] word;
    logic [31:0] w;

    // Unwritten words return a key-derived pattern, so an alias that lands
    // on the wrong offset or target reads back a different value
    function automatic logic [31:0] fill(input logic [37:0] k);
        return ~k[31:0] ^ {k[37:30], 24'h00_0000};
    endfunction

    always_comb key = {route.target, route.offset[31:2]};

    // Outside a route cycle the data is inverted rather than held
    always_comb begin
        word = mem.exists(key) ? mem[key] : fill(key);
        tgt_rdata = (route.valid === 1'b1) ? word : ~word;
    end

    always @(posedge core_clk) begin
        if (route.valid === 1'b1 && route.write === 1'b1) begin
            w = mem.exists(key) ? mem[key] : fill(key);
            for (int b = 0; b < 4; b++)
                if (route.strb[b])
                    w[8*b +: 8] = route.wdata[8*b +: 8];
            mem[key] = w;
        end
    end
endmodule
`default_nettype wire

// ### cbad_router_bench.sv
// Self-checking bench for the dual-bus address decoder and router
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    errors++; $display("unexpected at %0t: got %0h expected %0h", \
    $time, got, exp); end end
module cbad_router_bench
    import cbad_pkg::*;
;
    logic        core_clk       = 1'b0;
    logic        rstn           = 1'b0;
    cbad_req_t   dbus_req       = '0;
    cbad_req_t   ibus_req       = '0;
    logic [7:0]  perm_dbus      = 8'hFF;
    logic [7:0]  perm_ibus      = 8'hFF;
    logic        sram0_cache_en = 1'b0;
    logic        mst            = MST_CPU;
    logic [31:0] tgt_rdata;
    cbad_rsp_t   dbus_rsp;
    cbad_rsp_t   ibus_rsp;
    cbad_route_t route;
    logic        route_ibus;
    int          errors         = 0;
    int          checked        = 0;
    int          r_lat;
    logic        r_err;
    logic [31:0] r_rd;
    logic [7:0]  r_tgt;
    logic [31:0] r_off;
    logic [31:0] r_wd;
    logic [3:0]  r_strb;

    always #25 core_clk = ~core_clk;

    cbad_router u_cbad_router (
        .core_clk(core_clk), .rstn(rstn), .dbus_req(dbus_req),
        .ibus_req(ibus_req), .perm_dbus(perm_dbus), .perm_ibus(perm_ibus),
        .sram0_cache_en(sram0_cache_en), .tgt_rdata(tgt_rdata),
        .dbus_rsp(dbus_rsp), .ibus_rsp(ibus_rsp), .route(route),
        .route_ibus(route_ibus));

    cbad_mem_model u_cbad_mem_model (
        .core_clk(core_clk), .route(route), .tgt_rdata(tgt_rdata));

    task automatic print_verdict;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One transfer; the request is held until done, then dropped
    task automatic acc(input logic ib, input logic wr, input logic [1:0] sz,
                       input logic [31:0] a, input logic [31:0] wd);
        cbad_req_t q;
        cbad_rsp_t p;
        q = '{1'b1, wr, mst, sz, a, wd};
        r_tgt = 8'h00;
        r_lat = -1;
        @(negedge core_clk);
        if (ib)
            ibus_req = q;
        else
            dbus_req = q;
        for (int n = 0; n < 8 && r_lat < 0; n++) begin
            @(negedge core_clk);
            p = ib ? ibus_rsp : dbus_rsp;
            if (route.valid === 1'b1) begin
                r_tgt = route.target;
                r_off = route.offset;
                r_strb = route.strb;
                r_wd = route.wdata;
                `CHK(route_ibus, ib)
                `CHK(route.write, wr)
            end
            if (p.done === 1'b1) begin
                r_lat = n;
                r_err = p.err;
                r_rd = p.rdata;
            end
        end
        dbus_req = '0;
        ibus_req = '0;
        if (r_lat < 0) begin
            errors++;
            print_verdict();
        end else begin
            `CHK(r_lat, 1)
        end
    endtask

    task automatic map_chk(input logic ib, input logic [31:0] a,
                           input logic [7:0] t, input logic [31:0] o);
        acc(ib, 1'b0, SIZE_W, a, 32'h0);
        `CHK({r_err, r_tgt, r_off}, {1'b0, t, o})
    endtask

    task automatic bad(input logic ib, input logic wr, input logic [1:0] sz,
                       input logic [31:0] a);
        acc(ib, wr, sz, a, 32'h0);
        `CHK({r_err, r_tgt}, {1'b1, 8'h00})
    endtask

    task automatic t_map;
        map_chk(1'b0, 32'h3C00_0000, 8'h20, 32'h0);
        map_chk(1'b0, 32'h3C7F_FFFC, 8'h20, 32'h7F_FFFC);
        map_chk(1'b0, 32'h3FCD_FFFC, 8'h08, 32'h5_FFFC);
        map_chk(1'b0, 32'h3FF1_FFFC, 8'h02, 32'h1_FFFC);
        map_chk(1'b1, 32'h4003_FFFC, 8'h01, 32'h3_FFFC);
        map_chk(1'b1, 32'h4005_FFFC, 8'h02, 32'h1_FFFC);
        map_chk(1'b1, 32'h4037_C000, 8'h04, 32'h0);
        map_chk(1'b1, 32'h403D_FFFC, 8'h08, 32'h5_FFFC);
        map_chk(1'b1, 32'h427F_FFFC, 8'h20, 32'h7F_FFFC);
        map_chk(1'b0, 32'h5000_1FFC, 8'h10, 32'h1FFC);
        map_chk(1'b1, 32'h5000_0000, 8'h10, 32'h0);
        map_chk(1'b0, 32'h600D_0FFC, 8'h40, 32'hD_0FFC);
        map_chk(1'b1, 32'h6000_0000, 8'h40, 32'h0);
        bad(1'b0, 1'b0, SIZE_W, 32'h4000_0000);
        bad(1'b1, 1'b0, SIZE_W, 32'h3FC8_0000);
        bad(1'b0, 1'b0, SIZE_W, 32'h600D_1000);
        bad(1'b1, 1'b0, SIZE_W, 32'h4006_0000);
        bad(1'b0, 1'b0, SIZE_W, 32'h5000_2000);
    endtask

    task automatic t_alias;
        logic [31:0] v;
        acc(1'b0, 1'b1, SIZE_W, 32'h3FC8_0010, 32'hA5A5_1234);
        `CHK(r_strb, 4'hF)
        acc(1'b0, 1'b1, SIZE_B, 32'h3FC8_0012, 32'h0000_0077);
        `CHK({r_strb, r_wd}, {4'h4, 32'h0077_0000})
        acc(1'b0, 1'b1, SIZE_H, 32'h3FC8_0016, 32'h0000_BEEF);
        `CHK({r_strb, r_wd}, {4'hC, 32'hBEEF_0000})
        acc(1'b0, 1'b0, SIZE_H, 32'h3FC8_0012, 32'h0);
        `CHK(r_rd, 32'h0000_A577)
        acc(1'b0, 1'b0, SIZE_B, 32'h3FC8_0011, 32'h0);
        `CHK(r_rd, 32'h0000_0012)
        acc(1'b1, 1'b0, SIZE_W, 32'h4038_0010, 32'h0);
        `CHK(r_rd, 32'hA577_1234)
        acc(1'b0, 1'b0, SIZE_W, 32'h3FF0_0004, 32'h0);
        v = r_rd;
        acc(1'b1, 1'b0, SIZE_W, 32'h4004_0004, 32'h0);
        `CHK(r_rd, v)
        bad(1'b0, 1'b1, SIZE_W, 32'h3FF0_0004);
        bad(1'b1, 1'b1, SIZE_W, 32'h4000_0000);
        acc(1'b1, 1'b0, SIZE_W, 32'h4004_0004, 32'h0);
        `CHK(r_rd, v)
    endtask

    task automatic t_refuse;
        bad(1'b0, 1'b0, SIZE_W, 32'h3FC8_0002);
        bad(1'b0, 1'b0, SIZE_H, 32'h3FC8_0001);
        bad(1'b0, 1'b0, 2'h3, 32'h3FC8_0000);
        bad(1'b1, 1'b0, SIZE_B, 32'h4038_0000);
        bad(1'b1, 1'b0, SIZE_W, 32'h4038_0002);
        perm_dbus = 8'hF7;
        bad(1'b0, 1'b0, SIZE_W, 32'h3FC8_0000);
        map_chk(1'b1, 32'h4038_0000, 8'h08, 32'h0);
        perm_dbus = 8'hFF;
        perm_ibus = 8'hFE;
        bad(1'b1, 1'b0, SIZE_W, 32'h4000_0000);
        perm_ibus = 8'hFF;
        sram0_cache_en = 1'b1;
        bad(1'b1, 1'b0, SIZE_W, 32'h4037_C000);
        map_chk(1'b0, 32'h3FC8_0000, 8'h08, 32'h0);
        sram0_cache_en = 1'b0;
        map_chk(1'b1, 32'h4037_C004, 8'h04, 32'h4);
        mst = 1'b1;
        bad(1'b0, 1'b0, SIZE_W, 32'h5000_0000);
        bad(1'b1, 1'b1, SIZE_W, 32'h5000_1000);
        map_chk(1'b0, 32'h3FC8_0000, 8'h08, 32'h0);
        mst = MST_CPU;
    endtask

    initial begin
        repeat (6) @(negedge core_clk);
        `CHK({dbus_rsp, ibus_rsp, route}, '0)
        rstn = 1'b1;
        t_map();
        t_alias();
        t_refuse();
        print_verdict();
    end
endmodule
`default_nettype wire
